/* design/ffs_pkg.sv */
package ffs_pkg;
    // Timebase: one tick every 10 us at 100 MHz.
    localparam int CLK_HZ = 100000000;
    localparam int TICK_NS = 10000;
    localparam int TICK_CYCLES = TICK_NS / (1000000000 / CLK_HZ);
    // Fault timer durations in their own units and in ticks; blanking in cycles.
    localparam int RECOVERY_MS_X10 = 12000;
    localparam int RECOVERY_TICKS = (RECOVERY_MS_X10 * 100) / (TICK_NS / 1000);
    localparam int BROWNOUT_MS = 54;
    localparam int BROWNOUT_TICKS = (BROWNOUT_MS * 1000) / (TICK_NS / 1000);
    localparam int LINE_REMOVAL_MS = 100;
    localparam int LINE_REMOVAL_TICKS = (LINE_REMOVAL_MS * 1000) / (TICK_NS / 1000);
    localparam int RISE_RESET_MS = 14;
    localparam int RISE_RESET_TICKS = (RISE_RESET_MS * 1000) / (TICK_NS / 1000);
    localparam int FALL_RESET_MS = 1;
    localparam int FALL_RESET_TICKS = (FALL_RESET_MS * 1000) / (TICK_NS / 1000);
    localparam int BLANK_US = 30;
    localparam int BLANK_CYCLES = (BLANK_US * 1000 + (1000000000 / CLK_HZ) - 1)
        / (1000000000 / CLK_HZ);
    // Register map.
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_STATE = 4'h2;
    localparam logic [3:0] ADDR_CTRL = 4'h3;
    localparam int EV_W = 6;
    localparam int EV_LATCH = 0;
    localparam int EV_NONLATCH = 1;
    localparam int EV_AUTOREC = 2;
    localparam int EV_BROWNOUT = 3;
    localparam int EV_LINEREM = 4;
    localparam int EV_RESTART = 5;
    localparam logic [EV_W-1:0] MASK_RST = 6'h00;
    localparam int CTRL_OTP_LATCH = 0;
    localparam logic [1:0] CTRL_RST = 2'h0;
    typedef enum {
        ST_STARTUP, ST_RUN, ST_NONLATCH, ST_LATCHED, ST_AUTOREC, ST_DISCHARGE
    } ffs_state_t;
endpackage : ffs_pkg

/* design/flyback_fault_sequencer.sv */
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
// Functional notes
// - Faults handled as latch, nonlatch or autorecovery.
// - Latch faults kill drive, enter latched.
// - Latched never restarts at supply turn-on.
// - Latch cleared by supply reset or removal.
// - Nonlatch fault: drive off, cycle startup source.
// - After clearing, restart at turn-on if line ok.
// - Supply already high: restart at once.
// - Autorecovery fault: drive off, 1.2 s timer.
// - Startup source holds supply during recovery.
// - After recovery, restart at turn-on if line ok.
// - Line below stop for 54 ms declares brownout.
// - Brownout is nonlatch until line above start.
// - Line removal detection always runs.
// - Low slope runs 100 ms removal timer.
// - Slope reset timers 14/1 ms restart removal timer.
// - Removal expiry disables and starts discharge.
// - Discharge ends at completion level, restarts.
// - Fault pin needs 30 us persistence.
module ffs_flyback_fault_sequencer
    import ffs_pkg::*;
#(
    parameter int RECOVERY_TICKS_P = RECOVERY_TICKS,
    parameter int BROWNOUT_TICKS_P = BROWNOUT_TICKS,
    parameter int LINE_REMOVAL_TICKS_P = LINE_REMOVAL_TICKS,
    parameter int RISE_RESET_TICKS_P = RISE_RESET_TICKS,
    parameter int FALL_RESET_TICKS_P = FALL_RESET_TICKS,
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Comparator flags.
    input wire logic vccOn,
    input wire logic vccOff,
    input wire logic vccReset,
    input wire logic vccOvp,
    input wire logic abnormalOvercurrentFault,
    input wire logic thermalShutdown,
    input wire logic autoRecFault,
    input wire logic lineAboveBrownoutStart,
    input wire logic lineAboveBrownoutStop,
    input wire logic lineSlopeRise,
    input wire logic lineSlopeFall,
    input wire logic lineDischargeDone,
    input wire logic faultPinHigh,
    input wire logic faultPinLow,
    input wire logic softStart,
    // Power stage controls.
    output logic gateEnable,
    output logic startupSourceOn,
    output logic dischargeOn,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic irq
);
    localparam int NIN = 15;
    logic [NIN-1:0] rawIn;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    assign rawIn = {softStart, faultPinLow, faultPinHigh, lineDischargeDone, lineSlopeFall,
        lineSlopeRise, lineAboveBrownoutStop, lineAboveBrownoutStart, autoRecFault,
        thermalShutdown, abnormalOvercurrentFault, vccOvp, vccReset, vccOff, vccOn};

    // Two-stage synchronisers; only the second stage is used downstream.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= rawIn;
            sync2_r <= sync1_r;
        end
    end

    // Synchronised copies of the comparator flags.
    logic sVccOn;
    logic sVccOff;
    logic sVccReset;
    logic sOvp;
    logic sAocp;
    logic sTsd;
    logic sAuto;
    logic sBoStart;
    logic sBoStop;
    logic sRise;
    logic sFall;
    logic sDischDone;
    logic sFHigh;
    logic sFLow;
    logic sSoft;
    assign {sSoft, sFLow, sFHigh, sDischDone, sFall, sRise, sBoStop, sBoStart, sAuto,
        sTsd, sAocp, sOvp, sVccReset, sVccOff, sVccOn} = sync2_r;

    // Common timebase.
    logic [15:0] tbCnt_r;
    logic tick;
    assign tick = (tbCnt_r == 16'(TICK_CYCLES_P - 1));
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tbCnt_r <= '0;
        end else if (tick) begin
            tbCnt_r <= '0;
        end else begin
            tbCnt_r <= tbCnt_r + 16'h0001;
        end
    end

    // Fault pin blanking filters.
    // The filters saturate, so a fault held for a long time cannot wrap and release.
    logic [11:0] blankHi_r;
    logic [11:0] blankLo_r;
    logic fOvp;
    logic fOtp;
    assign fOvp = (blankHi_r == 12'(BLANK_CYCLES));
    assign fOtp = (blankLo_r == 12'(BLANK_CYCLES));
    always_ff @(posedge core_clk) begin
        if (rst || !sFHigh) begin
            blankHi_r <= '0;
        end else if (!fOvp) begin
            blankHi_r <= blankHi_r + 12'h001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || !sFLow || sSoft) begin
            blankLo_r <= '0;
        end else if (!fOtp) begin
            blankLo_r <= blankLo_r + 12'h001;
        end
    end

    // Control register.
    logic [1:0] ctrl_r;
    logic otpLatches;
    assign otpLatches = ctrl_r[CTRL_OTP_LATCH];

    // Brownout timer.
    // Brownout holds until the line climbs over the start level, giving hysteresis.
    logic [15:0] boCnt_r;
    logic brownout_r;
    always_ff @(posedge core_clk) begin
        if (rst || sBoStop) begin
            boCnt_r <= '0;
        end else if (tick && boCnt_r != 16'(BROWNOUT_TICKS_P)) begin
            boCnt_r <= boCnt_r + 16'h0001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            brownout_r <= 1'b0;
        end else if (boCnt_r == 16'(BROWNOUT_TICKS_P)) begin
            brownout_r <= 1'b1;
        end else if (sBoStart) begin
            brownout_r <= 1'b0;
        end
    end

    // Line removal detection, never gated by state.
    // The removal counter only runs while neither slope detector is active.
    logic [15:0] riseCnt_r;
    logic [15:0] fallCnt_r;
    logic [15:0] remCnt_r;
    logic riseFire;
    logic fallFire;
    logic lineRemoved;
    assign riseFire = tick && riseCnt_r == 16'(RISE_RESET_TICKS_P - 1);
    assign fallFire = tick && fallCnt_r == 16'(FALL_RESET_TICKS_P - 1);
    assign lineRemoved = tick && remCnt_r == 16'(LINE_REMOVAL_TICKS_P - 1);
    always_ff @(posedge core_clk) begin
        if (rst || !sRise || riseFire) begin
            riseCnt_r <= '0;
        end else if (tick) begin
            riseCnt_r <= riseCnt_r + 16'h0001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || !sFall || fallFire) begin
            fallCnt_r <= '0;
        end else if (tick) begin
            fallCnt_r <= fallCnt_r + 16'h0001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || riseFire || fallFire || lineRemoved) begin
            remCnt_r <= '0;
        end else if (tick && !sRise && !sFall) begin
            remCnt_r <= remCnt_r + 16'h0001;
        end
    end

    // Fault classification.
    logic latchFault;
    logic nonLatchFault;
    assign latchFault = sAocp || sOvp || fOvp || (fOtp && otpLatches);
    assign nonLatchFault = brownout_r || sTsd || (fOtp && !otpLatches);
    logic lineOk;
    assign lineOk = sBoStart;

    // Sequencer.
    ffs_state_t state_r;
    logic [23:0] arCnt_r;
    logic arDone;
    assign arDone = (arCnt_r == 24'(RECOVERY_TICKS_P));
    logic supplyCharge_r;

    // Line removal overrides every state, which is also what clears a latch.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ST_STARTUP;
        end else if (lineRemoved) begin
            state_r <= ST_DISCHARGE;
        end else begin
            case (state_r)
                ST_STARTUP: begin
                    if (latchFault) begin
                        state_r <= ST_LATCHED;
                    end else if (nonLatchFault) begin
                        state_r <= ST_NONLATCH;
                    end else if (sVccOn && lineOk) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (latchFault) begin
                        state_r <= ST_LATCHED;
                    end else if (nonLatchFault) begin
                        state_r <= ST_NONLATCH;
                    end else if (sAuto) begin
                        state_r <= ST_AUTOREC;
                    end
                end
                ST_NONLATCH: begin
                    if (latchFault) begin
                        state_r <= ST_LATCHED;
                    end else if (!nonLatchFault && sVccOn && lineOk) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_LATCHED: begin
                    if (sVccReset) begin
                        state_r <= ST_STARTUP;
                    end
                end
                ST_AUTOREC: begin
                    if (latchFault) begin
                        state_r <= ST_LATCHED;
                    end else if (arDone && sVccOn && lineOk && !supplyCharge_r) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_DISCHARGE: begin
                    if (sDischDone) begin
                        state_r <= ST_STARTUP;
                    end
                end
                default: state_r <= ST_STARTUP;
            endcase
        end
    end

    // Recovery timer, cleared whenever the sequencer is outside recovery.
    always_ff @(posedge core_clk) begin
        if (rst || state_r != ST_AUTOREC) begin
            arCnt_r <= '0;
        end else if (tick && !arDone) begin
            arCnt_r <= arCnt_r + 24'h000001;
        end
    end

    // Startup source hysteresis: on at turn-off level, off at turn-on level.
    // Charging from reset lets the supply climb without first sagging to turn-off.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            supplyCharge_r <= 1'b1;
        end else if (state_r == ST_RUN || state_r == ST_DISCHARGE) begin
            supplyCharge_r <= 1'b0;
        end else if (sVccOn) begin
            supplyCharge_r <= 1'b0;
        end else if (sVccOff || state_r == ST_STARTUP) begin
            supplyCharge_r <= 1'b1;
        end
    end

    // Outputs; the gate is dropped combinationally on a latch fault.
    // This saves a clock of exposure at the cost of a combinational path to the pin.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            startupSourceOn <= 1'b0;
            dischargeOn <= 1'b0;
        end else begin
            startupSourceOn <= supplyCharge_r;
            dischargeOn <= (state_r == ST_DISCHARGE);
        end
    end
    assign gateEnable = (state_r == ST_RUN) && !latchFault && !lineRemoved;

    // Event flags, set wins over clear.
    logic [EV_W-1:0] status_r;
    logic [EV_W-1:0] mask_r;
    logic [EV_W-1:0] events;
    ffs_state_t statePrev_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            statePrev_r <= ST_STARTUP;
        end else begin
            statePrev_r <= state_r;
        end
    end
    // Each state event is a one-cycle pulse on entry to its state.
    assign events[EV_LATCH] = state_r == ST_LATCHED && statePrev_r != ST_LATCHED;
    assign events[EV_NONLATCH] = state_r == ST_NONLATCH && statePrev_r != ST_NONLATCH;
    assign events[EV_AUTOREC] = state_r == ST_AUTOREC && statePrev_r != ST_AUTOREC;
    assign events[EV_BROWNOUT] = boCnt_r == 16'(BROWNOUT_TICKS_P) && !brownout_r;
    assign events[EV_LINEREM] = lineRemoved;
    assign events[EV_RESTART] = state_r == ST_RUN && statePrev_r != ST_RUN;

    // A written one clears a bit, but an event in the same cycle keeps it set.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~((regWr && regAddr == ADDR_STATUS) ?
                regWdata[EV_W-1:0] : '0)) | events;
        end
    end
    // Writes to addresses without a writable register are dropped.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_r <= MASK_RST;
            ctrl_r <= CTRL_RST;
        end else if (regWr && regAddr == ADDR_MASK) begin
            mask_r <= regWdata[EV_W-1:0];
        end else if (regWr && regAddr == ADDR_CTRL) begin
            ctrl_r <= regWdata[1:0];
        end
    end
    assign irq = |(status_r & mask_r);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            case (regAddr)
                ADDR_STATUS: begin
                    regRdata <= {2'h0, status_r};
                end
                ADDR_MASK: begin
                    regRdata <= {2'h0, mask_r};
                end
                ADDR_STATE: begin
                    regRdata <= {brownout_r, 4'h0, 3'(state_r)};
                end
                ADDR_CTRL: begin
                    regRdata <= {6'h00, ctrl_r};
                end
                default: begin
                    regRdata <= '0;
                end
            endcase
        end else begin
            regRdata <= '0;
        end
    end
endmodule : ffs_flyback_fault_sequencer

/* bench/ffs_monitor.sv */
`timescale 1ns/1ns
module ffs_monitor
    import ffs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Observed inputs.
    input wire logic vccOff,
    input wire logic vccReset,
    input wire logic vccOvp,
    input wire logic abnormalOvercurrentFault,
    input wire logic thermalShutdown,
    input wire logic autoRecFault,
    input wire logic lineDischargeDone,
    input wire logic [3:0] regAddr,
    input wire logic regRd,
    // Observed outputs.
    input wire logic gateEnable,
    input wire logic startupSourceOn,
    input wire logic dischargeOn,
    input wire logic [7:0] regRdata
);
    logic latchHeld_r;
    // Armed only once a latching fault has crossed the two-flop synchroniser.
    always_ff @(posedge core_clk) begin
        if (rst || vccReset || dischargeOn) begin
            latchHeld_r <= 1'h0;
        end else if ($past(vccOvp, 3) || $past(abnormalOvercurrentFault, 3)) begin
            latchHeld_r <= 1'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    latch_gate_off_a: assert property ($rose(vccOvp || abnormalOvercurrentFault) |->
        ##[1:3] !gateEnable) else $error("gate still on after latching fault");
    latch_hold_a: assert property (latchHeld_r |-> !gateEnable)
        else $error("latched device restarted");
    nonlatch_off_a: assert property (thermalShutdown [*4] |-> !gateEnable)
        else $error("gate on during thermal fault");
    autorec_off_a: assert property (autoRecFault [*4] |-> !gateEnable)
        else $error("gate on during recovery fault");
    source_cycle_a: assert property ((vccOff && !gateEnable && !dischargeOn) [*5]
        |-> startupSourceOn) else $error("startup source idle at turn-off level");
    disch_gate_a: assert property (dischargeOn |-> !gateEnable)
        else $error("gate on during discharge");
    disch_end_a: assert property ((dischargeOn && lineDischargeDone) [*5] |=>
        !dischargeOn) else $error("discharge outlasts completion level");
    rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside answer cycle");
    rd_unmapped_a: assert property (regRd && regAddr > ADDR_CTRL |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : ffs_monitor

bind ffs_flyback_fault_sequencer ffs_monitor u_mon (.*);

/* bench/ffs_supply_model.sv */
`timescale 1ns/1ns
module ffs_supply_model (
    // Clock.
    input wire logic core_clk,
    // Device controls.
    input wire logic gateEnable,
    input wire logic startupSourceOn,
    input wire logic vccDrop,
    // Supply comparators.
    output logic vccOn,
    output logic vccOff,
    output logic vccReset
);
    int level = 0;
    // The aux winding holds the supply only while switching; otherwise it sags.
    always @(posedge core_clk) begin
        if (vccDrop) begin
            level <= (level > 0) ? level - 1 : 0;
        end else if (gateEnable) begin
            level <= 90;
        end else if (startupSourceOn) begin
            level <= (level < 100) ? level + 1 : 100;
        end else if (level > 30) begin
            level <= level - 1;
        end
    end
    assign vccOn = level >= 80;
    assign vccOff = level <= 40;
    assign vccReset = level < 10;
endmodule : ffs_supply_model

/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top
    import ffs_pkg::*;
;
    logic core_clk = 1'h0, rst = 1'h1, vccOn, vccOff, vccReset, vccDrop = 1'h0;
    logic vccOvp = 1'h0, abnormalOvercurrentFault = 1'h0, thermalShutdown = 1'h0;
    logic autoRecFault = 1'h0, lineAboveBrownoutStart = 1'h1, lineAboveBrownoutStop = 1'h1;
    logic lineSlopeRise = 1'h1, lineSlopeFall = 1'h0, lineDischargeDone = 1'h0;
    logic faultPinHigh = 1'h0, faultPinLow = 1'h0, softStart = 1'h0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic regWr = 1'h0, regRd = 1'h0, gateEnable, startupSourceOn, dischargeOn, irq;
    int fails = 0, checks_done = 0, cyc = 0;
    always #5 core_clk = ~core_clk;
    ffs_flyback_fault_sequencer #(.RECOVERY_TICKS_P(40), .BROWNOUT_TICKS_P(20),
        .LINE_REMOVAL_TICKS_P(50), .RISE_RESET_TICKS_P(30), .FALL_RESET_TICKS_P(10),
        .TICK_CYCLES_P(2)) DUT (.*);
    ffs_supply_model u_sup (.core_clk(core_clk), .gateEnable(gateEnable),
        .startupSourceOn(startupSourceOn), .vccDrop(vccDrop), .vccOn(vccOn),
        .vccOff(vccOff), .vccReset(vccReset));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'h1; regAddr <= a; regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge core_clk);
        regRd <= 1'h1; regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'h0;
        #1 check(regRdata & m, exp);
    endtask : rd
    task automatic waitGate(input logic v, input int lim);
        int n = 0;
        while (gateEnable !== v && n < lim) begin
            @(posedge core_clk);
            #1 n++;
        end
        check(gateEnable, v);
    endtask : waitGate
    task automatic t_start();
        rd(ADDR_MASK, 8'hff, MASK_RST);
        rd(ADDR_CTRL, 8'hff, {6'h00, CTRL_RST});
        rd(4'hf, 8'hff, 8'h00);
        waitGate(1'h1, 400);
        rd(ADDR_STATE, 8'h07, 8'h01);
    endtask : t_start
    task automatic t_latch();
        wr(ADDR_STATUS, 8'h3f);
        wr(ADDR_MASK, 8'h01);
        abnormalOvercurrentFault <= 1'h1;
        waitGate(1'h0, 4);
        abnormalOvercurrentFault <= 1'h0;
        repeat (2) @(posedge core_clk);
        rd(ADDR_STATUS, 8'h01, 8'h01);
        check(irq, 1'h1);
        wr(ADDR_MASK, 8'h00);
        #1 check(irq, 1'h0);
        repeat (400) @(posedge core_clk);
        rd(ADDR_STATE, 8'h07, 8'h03);
        vccDrop <= 1'h1;
        repeat (100) @(posedge core_clk);
        vccDrop <= 1'h0;
        waitGate(1'h1, 400);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, 8'h01, 8'h00);
        check(irq, 1'h0);
    endtask : t_latch
    task automatic t_nonlatch();
        thermalShutdown <= 1'h1;
        repeat (4) @(posedge core_clk);
        thermalShutdown <= 1'h0;
        check(gateEnable, 1'h0);
        waitGate(1'h1, 6);
        thermalShutdown <= 1'h1;
        waitGate(1'h0, 6);
        rd(ADDR_STATE, 8'h07, 8'h02);
        repeat (150) @(posedge core_clk);
        thermalShutdown <= 1'h0;
        waitGate(1'h1, 300);
    endtask : t_nonlatch
    task automatic t_autorec();
        autoRecFault <= 1'h1;
        waitGate(1'h0, 6);
        autoRecFault <= 1'h0;
        rd(ADDR_STATE, 8'h07, 8'h04);
        repeat (50) @(posedge core_clk);
        #1 check(gateEnable, 1'h0);
        waitGate(1'h1, 300);
    endtask : t_autorec
    task automatic t_faultpin();
        softStart <= 1'h1;
        faultPinLow <= 1'h1;
        repeat (3100) @(posedge core_clk);
        #1 check(gateEnable, 1'h1);
        softStart <= 1'h0;
        repeat (2990) @(posedge core_clk);
        #1 check(gateEnable, 1'h1);
        waitGate(1'h0, 20);
        rd(ADDR_STATE, 8'h07, 8'h02);
        faultPinLow <= 1'h0;
        waitGate(1'h1, 300);
    endtask : t_faultpin
    task automatic t_brownout();
        wr(ADDR_STATUS, 8'h3f);
        {lineAboveBrownoutStart, lineAboveBrownoutStop} <= 2'h0;
        repeat (30) @(posedge core_clk);
        {lineAboveBrownoutStart, lineAboveBrownoutStop} <= 2'h3;
        rd(ADDR_STATUS, 8'h08, 8'h00);
        {lineAboveBrownoutStart, lineAboveBrownoutStop} <= 2'h0;
        waitGate(1'h0, 60);
        rd(ADDR_STATUS, 8'h08, 8'h08);
        rd(ADDR_STATE, 8'h87, 8'h82);
        repeat (200) @(posedge core_clk);
        {lineAboveBrownoutStart, lineAboveBrownoutStop} <= 2'h3;
        waitGate(1'h1, 300);
    endtask : t_brownout
    task automatic t_removal();
        int n = 0;
        lineSlopeRise <= 1'h0;
        repeat (70) @(posedge core_clk);
        lineSlopeFall <= 1'h1;
        repeat (30) @(posedge core_clk);
        lineSlopeFall <= 1'h0;
        repeat (70) @(posedge core_clk);
        #1 check(dischargeOn, 1'h0);
        while (dischargeOn !== 1'h1 && n < 60) begin
            @(posedge core_clk);
            #1 n++;
        end
        check(dischargeOn, 1'h1);
        rd(ADDR_STATE, 8'h07, 8'h05);
        lineDischargeDone <= 1'h1;
        repeat (6) @(posedge core_clk);
        #1 check(dischargeOn, 1'h0);
        lineDischargeDone <= 1'h0;
        lineSlopeRise <= 1'h1;
        waitGate(1'h1, 400);
    endtask : t_removal
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    // The whole sequence needs about 8000 cycles; the ceiling leaves wide margin.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'h0;
        t_start();
        t_latch();
        t_nonlatch();
        t_autorec();
        t_faultpin();
        t_brownout();
        t_removal();
        conclude();
    end
endmodule : tb_top
